// *** common/dsadc_defines.svh ***
// Register layout, reset value and timing constants for the delta-sigma converter control
`ifndef DSADC_DEFINES_SVH
`define DSADC_DEFINES_SVH
`define DSADC_ADDR_W         4
`define DSADC_ADDR_CTRL      4'h0
`define DSADC_ADDR_STATUS    4'h1
`define DSADC_ADDR_SAR       4'h2
`define DSADC_CTRL_RESET     8'h00
`define DSADC_CTRL_WMASK     8'hF3
`define DSADC_BIT_POWER      7
`define DSADC_BIT_RUN        6
`define DSADC_BIT_HIACC      5
`define DSADC_BIT_DIFF       4
`define DSADC_PAIR_MSB       1
`define DSADC_PAIR_LSB       0
`define DSADC_PAIR_BAD       2'h3
`define DSADC_CLK_PS         10000
`define DSADC_SETTLE_PS      1200000
`define DSADC_INIT_CYCLES    4
`define DSADC_NUM_PAIRS      3
`endif

// *** common/dsadc_pkg.sv ***
// Types shared by the delta-sigma converter control files
package dsadc_pkg;
  // Gray coded along idle -> settle -> ready -> init -> convert
  typedef enum logic [2:0] {
    DSADC_OFF     = 3'b000,
    DSADC_SETTLE  = 3'b001,
    DSADC_READY   = 3'b011,
    DSADC_INIT    = 3'b010,
    DSADC_CONVERT = 3'b110
  } dsadc_state_t;
endpackage

// *** hdl/dsadc_sync.sv ***
// Two-stage synchroniser for a vector of pin-level inputs
`timescale 1ns/1ps
module dsadc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_b,
  input  wire logic             i_ce,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } dsadc_sync_t;

  dsadc_sync_t st;
  dsadc_sync_t next_st;

  // First stage feeds only the second
  always_comb begin
    next_st        = st;
    next_st.meta   = i_async;
    next_st.stable = st.meta;
  end

  // Frozen while the clock enable is low
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      st <= '0;
    end else if (i_ce) begin
      st <= next_st;
    end
  end

  assign o_sync = st.stable;
endmodule

// *** hdl/dsadc_ctrl.sv ***
// Control register and sequencer for the 16-bit delta-sigma converter
//
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "dsadc_defines.svh"
module dsadc_ctrl #(
  parameter int SETTLE_PS  = `DSADC_SETTLE_PS,
  parameter int INIT_CYCLES = `DSADC_INIT_CYCLES
) (
  input  wire logic                     i_clk,
  input  wire logic                     i_rst_b,
  input  wire logic                     i_ce,
  input  wire logic [`DSADC_ADDR_W-1:0] i_addr,
  input  wire logic [7:0]               i_wdata,
  input  wire logic                     i_wr,
  input  wire logic                     i_rd,
  output logic      [7:0]               o_rdata,
  input  wire logic [`DSADC_NUM_PAIRS-1:0] i_sar_pin_config,
  input  wire logic                     i_sar_conversion_run,
  input  wire logic                     i_stop_req,
  output logic                          o_converter_power_on,
  output logic                          o_conversion_run,
  output logic                          o_conv_reset,
  output logic                          o_high_accuracy_select,
  output logic                          o_differential_input_select,
  output logic      [`DSADC_NUM_PAIRS-1:0] o_pair_enable
);
  // Settle time in cycles, rounded up since it is a least time
  localparam int SETTLE_CYC = (SETTLE_PS + `DSADC_CLK_PS - 1) / `DSADC_CLK_PS;
  localparam int CNT_W      = $clog2(SETTLE_CYC + INIT_CYCLES + 1);

  typedef struct packed {
    logic [7:0]                  ctrl;
    dsadc_pkg::dsadc_state_t     fsm;
    logic [CNT_W-1:0]            cnt;
    logic [7:0]                  rdata;
    logic                        err_early;
    logic                        err_pair;
    logic                        err_both;
    logic                        err_stop;
    logic                        power;
    logic                        run;
    logic                        conv_reset;
    logic                        hiacc;
    logic                        diff;
    logic [`DSADC_NUM_PAIRS-1:0] pair_en;
  } dsadc_ctrl_t;

  dsadc_ctrl_t st;
  dsadc_ctrl_t next_st;

  logic [`DSADC_NUM_PAIRS-1:0] sar_pins;
  logic [1:0]                  sar_run_s;
  logic                        ctrl_wr;
  logic [7:0]                  wval;
  logic [1:0]                  pair;
  logic [7:0]                  status;

  // Sideband inputs come from other domains, so synchronise them
  dsadc_sync #(
    .WIDTH(`DSADC_NUM_PAIRS + 2)
  ) u_sync (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_ce    (i_ce),
    .i_async ({i_sar_pin_config, i_sar_conversion_run, i_stop_req}),
    .o_sync  ({sar_pins, sar_run_s})
  );

  assign ctrl_wr = i_wr && (i_addr == `DSADC_ADDR_CTRL);
  assign wval    = i_wdata & `DSADC_CTRL_WMASK;
  assign pair    = st.ctrl[`DSADC_PAIR_MSB:`DSADC_PAIR_LSB];
  assign status  = {st.err_stop, st.err_both, st.err_pair, st.err_early, 1'b0, st.fsm};

  always_comb begin
    next_st            = st;
    next_st.conv_reset = 1'b0;
    // Register writes; bits 3 and 2 never stored
    if (ctrl_wr) begin
      next_st.ctrl = wval;
      // Power and run together, or run before settling, is flagged
      if (wval[`DSADC_BIT_RUN] && (!st.ctrl[`DSADC_BIT_POWER] || st.fsm == dsadc_pkg::DSADC_SETTLE)) begin
        next_st.err_early = 1'b1;
      end
      if (wval[`DSADC_PAIR_MSB:`DSADC_PAIR_LSB] == `DSADC_PAIR_BAD) begin
        next_st.err_pair = 1'b1;
      end
    end else if (i_wr && (i_addr == `DSADC_ADDR_STATUS)) begin
      // Write one to clear sticky error flags
      next_st.err_stop  = st.err_stop & ~i_wdata[7];
      next_st.err_both  = st.err_both & ~i_wdata[6];
      next_st.err_pair  = st.err_pair & ~i_wdata[5];
      next_st.err_early = st.err_early & ~i_wdata[4];
    end
    // Misuse detection; set wins over clear
    if (pair != `DSADC_PAIR_BAD && sar_pins[pair] && st.ctrl[`DSADC_BIT_POWER]) begin
      next_st.err_pair = 1'b1;
    end
    if (st.run && sar_run_s[1]) begin
      next_st.err_both = 1'b1;
    end
    if (sar_run_s[0] && st.ctrl[`DSADC_BIT_POWER]) begin
      next_st.err_stop = 1'b1;
    end
    // Sequencer
    case (st.fsm)
      dsadc_pkg::DSADC_OFF: begin
        next_st.cnt = '0;
        if (st.ctrl[`DSADC_BIT_POWER]) begin
          next_st.fsm = dsadc_pkg::DSADC_SETTLE;
        end
      end
      dsadc_pkg::DSADC_SETTLE: begin
        next_st.cnt = st.cnt + 1'b1;
        if (CNT_W'(SETTLE_CYC - 1) == st.cnt) begin
          next_st.fsm = dsadc_pkg::DSADC_READY;
        end
      end
      dsadc_pkg::DSADC_READY: begin
        next_st.cnt = '0;
        if (st.ctrl[`DSADC_BIT_RUN]) begin
          next_st.fsm = dsadc_pkg::DSADC_INIT;
        end
      end
      dsadc_pkg::DSADC_INIT: begin
        next_st.cnt        = st.cnt + 1'b1;
        if (CNT_W'(INIT_CYCLES - 1) == st.cnt) begin
          next_st.fsm = dsadc_pkg::DSADC_CONVERT;
        end
      end
      dsadc_pkg::DSADC_CONVERT: begin
        next_st.cnt = '0;
        if (!st.ctrl[`DSADC_BIT_RUN]) begin
          next_st.fsm = dsadc_pkg::DSADC_READY;
        end
      end
      default: begin
        next_st.fsm = dsadc_pkg::DSADC_OFF;
      end
    endcase
    // A powered control write in init or convert restarts from init, even same data; with run clear it goes to ready
    if (ctrl_wr && st.ctrl[`DSADC_BIT_POWER] && wval[`DSADC_BIT_POWER]
        && (st.fsm == dsadc_pkg::DSADC_INIT || st.fsm == dsadc_pkg::DSADC_CONVERT)) begin
      next_st.cnt = '0;
      next_st.fsm = wval[`DSADC_BIT_RUN] ? dsadc_pkg::DSADC_INIT : dsadc_pkg::DSADC_READY;
    end
    // Power removal always wins
    if (!next_st.ctrl[`DSADC_BIT_POWER]) begin
      next_st.fsm = dsadc_pkg::DSADC_OFF;
      next_st.cnt = '0;
    end
    // Registered outputs
    next_st.power = next_st.ctrl[`DSADC_BIT_POWER];
    next_st.run   = (next_st.fsm == dsadc_pkg::DSADC_CONVERT);
    // Init pulse tracks the state itself, so it never overlaps run
    next_st.conv_reset = (next_st.fsm == dsadc_pkg::DSADC_INIT);
    next_st.hiacc = next_st.ctrl[`DSADC_BIT_HIACC];
    next_st.diff  = next_st.ctrl[`DSADC_BIT_DIFF];
    for (int i = 0; i < `DSADC_NUM_PAIRS; i++) begin
      next_st.pair_en[i] = next_st.ctrl[`DSADC_BIT_POWER]
                           && (next_st.ctrl[`DSADC_PAIR_MSB:`DSADC_PAIR_LSB] == 2'(i));
    end
    // Read port; unmapped addresses read zero
    if (i_rd) begin
      if (i_addr == `DSADC_ADDR_CTRL) begin
        next_st.rdata = st.ctrl;
      end else if (i_addr == `DSADC_ADDR_STATUS) begin
        next_st.rdata = status;
      end else if (i_addr == `DSADC_ADDR_SAR) begin
        next_st.rdata = {5'h00, sar_pins};
      end else begin
        next_st.rdata = 8'h00;
      end
    end else begin
      next_st.rdata = 8'h00;
    end
  end

  // Single state register, frozen when the clock enable is low
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      st      <= '0;
      st.ctrl <= `DSADC_CTRL_RESET;
      st.fsm  <= dsadc_pkg::DSADC_OFF;
    end else if (i_ce) begin
      st <= next_st;
    end
  end

  assign o_rdata                     = st.rdata;
  assign o_converter_power_on        = st.power;
  assign o_conversion_run            = st.run;
  assign o_conv_reset                = st.conv_reset;
  assign o_high_accuracy_select      = st.hiacc;
  assign o_differential_input_select = st.diff;
  assign o_pair_enable               = st.pair_en;
endmodule

// *** tb/dsadc_ctrl_sva.sv ***
// Port-level property checker for the converter control block
`timescale 1ns/1ps
`include "dsadc_defines.svh"
module dsadc_ctrl_sva (
  input wire logic                     i_clk,
  input wire logic                     i_rst_b,
  input wire logic                     i_ce,
  input wire logic [`DSADC_ADDR_W-1:0] i_addr,
  input wire logic [7:0]               i_wdata,
  input wire logic                     i_wr,
  input wire logic                     i_rd,
  input wire logic [7:0]               o_rdata,
  input wire logic                     o_converter_power_on,
  input wire logic                     o_conversion_run,
  input wire logic                     o_conv_reset,
  input wire logic                     o_high_accuracy_select,
  input wire logic                     o_differential_input_select,
  input wire logic [2:0]               o_pair_enable
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // Control write taken at this edge
  logic cw;
  assign cw = i_wr && i_ce && i_addr == `DSADC_ADDR_CTRL;
  power_follow_a: assert property (cw |=> o_converter_power_on == $past(i_wdata[7]))
    else $error("power output differs from written bit");
  hiacc_follow_a: assert property (cw |=> o_high_accuracy_select == $past(i_wdata[5]))
    else $error("accuracy output differs from written bit");
  diff_follow_a: assert property (cw |=> o_differential_input_select == $past(i_wdata[4]))
    else $error("input mode output differs from written bit");
  pair_sel_a: assert property (cw |=> o_pair_enable == (($past(i_wdata[7]) && $past(i_wdata[1:0]) != 2'h3) ?
    3'h1 << $past(i_wdata[1:0]) : 3'h0)) else $error("pair enable wrong");
  rewrite_init_a: assert property (cw && i_wdata[7:6] == 2'h3 && o_conversion_run |=> o_conv_reset && !o_conversion_run)
    else $error("rewrite did not restart init");
  run_stop_a: assert property (cw && !i_wdata[6] |=> !o_conversion_run)
    else $error("conversion kept running after stop");
  off_quiet_a: assert property (!o_converter_power_on |-> !o_conversion_run && !o_conv_reset && o_pair_enable == 3'h0)
    else $error("activity while unpowered");
  fixed_zero_a: assert property (i_rd && i_ce && i_addr == `DSADC_ADDR_CTRL |=> o_rdata[3:2] == 2'h0)
    else $error("fixed bits read nonzero");
  cover property ($rose(o_conv_reset));
  cover property ($rose(o_conversion_run));
  cover property (cw && i_wdata[1:0] == 2'h2);
endmodule
bind dsadc_ctrl dsadc_ctrl_sva i_sva (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(i_ce), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_converter_power_on(o_converter_power_on),
  .o_conversion_run(o_conversion_run), .o_conv_reset(o_conv_reset), .o_high_accuracy_select(o_high_accuracy_select),
  .o_differential_input_select(o_differential_input_select), .o_pair_enable(o_pair_enable));

// *** tb/tb.sv ***
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`include "dsadc_defines.svh"
module tb;
  logic i_clk, i_rst_b, i_wr, i_rd, pw, run, cres, hi, df, ce, srun, stp;
  logic [2:0] sar;
  logic [3:0] i_addr;
  logic [7:0] i_wdata, o_rdata, v, d;
  logic [2:0] pen;
  int mismatches, n_checks, seed, cyc, k;
  // Short settle and init so the run stays brief
  dsadc_ctrl #(.SETTLE_PS(50000), .INIT_CYCLES(2)) i_dsadc_ctrl (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(ce),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_sar_pin_config(sar),
    .i_sar_conversion_run(srun), .i_stop_req(stp), .o_converter_power_on(pw), .o_conversion_run(run),
    .o_conv_reset(cres), .o_high_accuracy_select(hi), .o_differential_input_select(df), .o_pair_enable(pen));
  // Clock generator
  initial begin
    i_clk = 0;
    forever #5 i_clk = ~i_clk;
  end
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // One-cycle bus strobes; outputs settle 1 ns after the taking edge
  task wr(input logic [3:0] a, input logic [7:0] dd);
    @(posedge i_clk);
    i_wr <= 1; i_addr <= a; i_wdata <= dd;
    @(posedge i_clk);
    i_wr <= 0;
    #1;
  endtask
  task rd(input logic [3:0] a, output logic [7:0] q);
    @(posedge i_clk);
    i_rd <= 1; i_addr <= a;
    @(posedge i_clk);
    i_rd <= 0;
    #1 q = o_rdata;
  endtask
  // Expected pair enables from the stored control value
  function logic [2:0] pmod(input logic [7:0] c);
    return (c[7] && c[1:0] != 2'h3) ? 3'h1 << c[1:0] : 3'h0;
  endfunction
  // Wait, bounded, for a level on an output
  task waitfor(input int sel);
    for (k = 0; k < 50 && (sel ? run : cres) !== 1'b1; k++) @(posedge i_clk);
    #1;
  endtask
  // Hang guard well above the expected run length
  always @(posedge i_clk) begin
    cyc++;
    if (cyc > 3000) begin
      mismatches++;
      stop_test();
    end
  end
  initial begin
    {i_wr, i_rd, i_addr, i_wdata, mismatches, n_checks, cyc, sar, srun, stp} = 0;
    ce = 1;
    seed = 40828;
    i_rst_b = 0;
    repeat (12) @(posedge i_clk);
    i_rst_b <= 1;
    rd(`DSADC_ADDR_CTRL, v);
    chk(v, `DSADC_CTRL_RESET);
    chk({pw, run, cres, hi, df, pen}, 8'h00);
    $display("reset test done");
    // Random fields, all pair codes, run bit kept low
    for (int i = 0; i < 8; i++) begin
      d = ($random(seed) & 8'hBC) | i[1:0];
      wr(`DSADC_ADDR_CTRL, d);
      chk({pw, hi, df}, {d[7], d[5], d[4]});
      chk(pen, pmod(d));
      rd(`DSADC_ADDR_CTRL, v);
      chk(v, d & 8'hF3);
    end
    rd(4'hF, v);
    chk(v, 8'h00);
    $display("field test done");
    // Power, settle, run, identical rewrite, stop
    wr(`DSADC_ADDR_CTRL, 8'h80);
    repeat (10) @(posedge i_clk);
    wr(`DSADC_ADDR_CTRL, 8'hC0);
    waitfor(0);
    chk(cres, 1'b1);
    waitfor(1);
    chk({run, cres}, 8'h02);
    wr(`DSADC_ADDR_CTRL, 8'hC0);
    chk({run, cres}, 8'h01);
    waitfor(1);
    wr(`DSADC_ADDR_CTRL, 8'h80);
    chk({pw, run}, 8'h02);
    wr(`DSADC_ADDR_CTRL, 8'h00);
    chk({pw, run, pen}, 8'h00);
    $display("sequence test done");
    // Software misuse is only flagged: power with run, SAR pin clash, both running, stop while powered
    wr(`DSADC_ADDR_STATUS, 8'hF0);
    wr(`DSADC_ADDR_CTRL, 8'hC1);
    @(posedge i_clk);
    sar <= 3'h2;
    srun <= 1;
    stp <= 1;
    repeat (15) @(posedge i_clk);
    rd(`DSADC_ADDR_STATUS, v);
    chk(v[7:4], 4'hF);
    // Writes are ignored while the clock enable is low
    @(posedge i_clk);
    ce <= 0;
    wr(`DSADC_ADDR_CTRL, 8'h00);
    ce <= 1;
    chk(pw, 1'b1);
    @(posedge i_clk);
    {sar, srun, stp} <= 0;
    wr(`DSADC_ADDR_CTRL, 8'h00);
    chk({pw, run, pen}, 8'h00);
    $display("misuse test done");
    stop_test();
  end
endmodule
